// [hdl/filter_accelerator_regs.svh]
// Constants of the filter accelerator: widths, field positions, codes and reset values.
// Summary of operation
// - Multiply two 24-bit operands into 48-bit accumulator.
// - Pass accumulator bits 46:23 to the ALU.
// - Operands are fractions, point after the MSB.
// - All other datapath paths are 24 bits.
// - ALU adds, subtracts, compares, thresholds, abs, squelch, saturates.
// - Seven control fields, 18 bits, steer each cycle.
// - Separate sample/coefficient RAMs, routing, shift, hold, round.
// - Memories hold 64 sample and coefficient pairs.
// - One 64-tap filter or four 16-tap filters.
// - Sustain about one FIR tap per clock.
// - Samples and results cross the system bus.
`ifndef FILTER_ACCELERATOR_REGS_SVH
`define FILTER_ACCELERATOR_REGS_SVH
`define DATA_W 24
`define ACC_W 48
`define TAP_HI 46
`define TAP_LO 23
`define ROUND_BIT 22
`define PAIRS 64
`define ADDR_W 6
`define BANK_W 2
`define CTL_W 18
`define CTL_MAC_LSB 16
`define CTL_ALU_LSB 12
`define CTL_ADDR_LSB 6
`define CTL_BSEL_LSB 4
`define CTL_SHIFT_LSB 2
`define CTL_DEST_LSB 1
`define CTL_ROUND_LSB 0
`define BUF_DEPTH 2
`define ACC_RST 48'h000000000000
`define HOLD_RST 24'h000000
`define POS_MAX 24'h7FFFFF
`define NEG_MAX 24'h800000
`define ONE_LSB 24'h000001
`define MINUS_ONE 24'hFFFFFF
`define HALF 24'h400000
`define QUARTER 24'h200000
`endif

// [hdl/filter_accelerator_pkg.sv]
// Types shared by the filter accelerator files.
`include "filter_accelerator_regs.svh"
package filter_accelerator_pkg;
  typedef enum logic [1:0] {MAC_HOLD, MAC_ACC, MAC_LOAD, MAC_CLEAR} mac_op_type;
  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_CMP, ALU_THRESH, ALU_ABS, ALU_SQUELCH, ALU_SAT
  } alu_op_type;
  typedef enum logic [1:0] {B_HOLD_A, B_HOLD_B, B_SAMPLE, B_ZERO} bsel_type;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT1, SH_RIGHT1, SH_RIGHT2} shift_type;
  typedef struct packed {
    logic [1:0] mac_op;
    logic [3:0] alu_op;
    logic [`ADDR_W-1:0] addr;
    logic [1:0] bsel;
    logic [1:0] shift;
    logic dest_out;
    logic round;
  } ctl_word_type;
  typedef struct packed {
    logic we;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } ram_wr_type;
endpackage

// [hdl/result_buffer.sv]
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
`include "filter_accelerator_regs.svh"
module result_buffer #(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `BUF_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [IDX_W-1:0] wr_ff;
  logic [IDX_W-1:0] rd_ff;
  logic [CNT_W-1:0] cnt_ff;
  wire logic push = i_in_valid && o_in_ready;
  wire logic pop = o_out_valid && i_out_ready;
  wire logic [IDX_W-1:0] nxt_wr = (wr_ff == IDX_W'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
  wire logic [IDX_W-1:0] nxt_rd = (rd_ff == IDX_W'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
  wire logic [CNT_W-1:0] nxt_cnt = cnt_ff + CNT_W'(push) - CNT_W'(pop);

  // A full buffer drops ready, which stalls the whole datapath upstream.
  assign o_in_ready = (cnt_ff != CNT_W'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= nxt_wr;
      if (pop) rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  buf_bound_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cnt_ff <= CNT_W'(DEPTH))
    else $error("Result buffer count exceeds its depth.");
  buf_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("Stalled result changed or vanished.");
  buf_full_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !o_in_ready ##1 pop);
endmodule
`default_nettype wire

// [hdl/filter_accelerator.sv]
// Filter accelerator: numeric datapath with MAC, ALU, pair RAMs and result buffer.
`timescale 1ns/10ps
`default_nettype none
`include "filter_accelerator_regs.svh"
module filter_accelerator #(
  parameter int PAIRS = `PAIRS
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ctl_valid,
  input wire filter_accelerator_pkg::ctl_word_type i_ctl_word,
  output logic o_ctl_ready,
  input wire filter_accelerator_pkg::ram_wr_type i_smp_wr,
  input wire filter_accelerator_pkg::ram_wr_type i_coef_wr,
  output logic o_res_valid,
  output logic [`DATA_W-1:0] o_res_data,
  input wire logic i_res_ready,
  output logic o_alu_flag
);
  logic signed [`ACC_W-1:0] acc_ff;
  logic [`DATA_W-1:0] hold_a_ff;
  logic [`DATA_W-1:0] hold_b_ff;
  logic alu_flag_ff;
  logic [`DATA_W-1:0] smp_ram_ff [PAIRS];
  logic [`DATA_W-1:0] coef_ram_ff [PAIRS];
  logic buf_in_ready;

  // Both RAMs share one pair index; the top two bits pick one of four 16-tap banks.
  wire logic taken = i_ctl_valid && o_ctl_ready;
  wire logic [`ADDR_W-1:0] pair_idx = i_ctl_word.addr;
  wire logic [`BANK_W-1:0] bank_sel = pair_idx[`ADDR_W-1 -: `BANK_W];
  wire logic signed [`DATA_W-1:0] smp_rd = smp_ram_ff[pair_idx];
  wire logic signed [`DATA_W-1:0] coef_rd = coef_ram_ff[pair_idx];

  // Full 48-bit product of two Q1.23 fractions; it carries a duplicate sign bit.
  wire logic signed [`ACC_W-1:0] product = smp_rd * coef_rd;
  wire logic signed [`ACC_W-1:0] acc_sum = acc_ff + product;
  wire filter_accelerator_pkg::mac_op_type mac_op =
    filter_accelerator_pkg::mac_op_type'(i_ctl_word.mac_op);
  wire logic signed [`ACC_W-1:0] nxt_acc =
    (mac_op == filter_accelerator_pkg::MAC_ACC) ? acc_sum :
    (mac_op == filter_accelerator_pkg::MAC_LOAD) ? product :
    (mac_op == filter_accelerator_pkg::MAC_CLEAR) ? `ACC_RST : acc_ff;

  // Tap skips the redundant sign bit so the ALU sees a Q1.23 value.
  wire logic [`DATA_W-1:0] mac_tap = acc_ff[`TAP_HI:`TAP_LO];
  wire logic round_up = i_ctl_word.round && acc_ff[`ROUND_BIT];
  wire logic round_ovf = round_up && (mac_tap == `POS_MAX);
  wire logic [`DATA_W-1:0] rounded = round_ovf ? `POS_MAX :
    mac_tap + `DATA_W'(round_up);

  wire filter_accelerator_pkg::bsel_type bsel =
    filter_accelerator_pkg::bsel_type'(i_ctl_word.bsel);
  wire logic [`DATA_W-1:0] opnd_b =
    (bsel == filter_accelerator_pkg::B_HOLD_A) ? hold_a_ff :
    (bsel == filter_accelerator_pkg::B_HOLD_B) ? hold_b_ff :
    (bsel == filter_accelerator_pkg::B_SAMPLE) ? smp_rd : `HOLD_RST;

  // Clamp a widened signed value to the 24-bit range.
  function automatic logic [`DATA_W-1:0] sat24(input logic signed [`DATA_W+1:0] v);
    logic [`DATA_W-1:0] r;
    r = v[`DATA_W-1:0];
    if (v > $signed({2'b00, `POS_MAX})) r = `POS_MAX;
    if (v < $signed({2'b11, `NEG_MAX})) r = `NEG_MAX;
    return r;
  endfunction

  // One ALU pass; bit 24 of the result is the condition flag.
  function automatic logic [`DATA_W:0] alu_calc(input logic [3:0] op,
                                                 input logic signed [`DATA_W-1:0] a,
                                                 input logic signed [`DATA_W-1:0] b);
    logic signed [`DATA_W+1:0] wa;
    logic signed [`DATA_W+1:0] wb;
    logic signed [`DATA_W+1:0] mag_a;
    logic [`DATA_W:0] r;
    wa = {{2{a[`DATA_W-1]}}, a};
    wb = {{2{b[`DATA_W-1]}}, b};
    mag_a = a[`DATA_W-1] ? -wa : wa;
    r = {1'b0, a};
    unique case (filter_accelerator_pkg::alu_op_type'(op))
      filter_accelerator_pkg::ALU_PASS: r = {1'b0, a};
      filter_accelerator_pkg::ALU_ADD: r = {1'b0, sat24(wa + wb)};
      filter_accelerator_pkg::ALU_SUB: r = {1'b0, sat24(wa - wb)};
      filter_accelerator_pkg::ALU_CMP:
        r = (a > b) ? {1'b1, `ONE_LSB} : (a == b) ? {1'b0, `HOLD_RST} : {1'b0, `MINUS_ONE};
      filter_accelerator_pkg::ALU_THRESH:
        r = (mag_a >= wb) ? {1'b1, `ONE_LSB} : {1'b0, `HOLD_RST};
      filter_accelerator_pkg::ALU_ABS: r = {1'b0, sat24(mag_a)};
      // Squelch mutes anything whose magnitude stays below the level in b.
      filter_accelerator_pkg::ALU_SQUELCH:
        r = (mag_a < wb) ? {1'b1, `HOLD_RST} : {1'b0, a};
      // Saturation clamps a to plus or minus the magnitude given in b.
      filter_accelerator_pkg::ALU_SAT: begin
        if (wa > (b[`DATA_W-1] ? -wb : wb)) begin
          r = {1'b1, sat24(b[`DATA_W-1] ? -wb : wb)};
        end else if (wa < (b[`DATA_W-1] ? wb : -wb)) begin
          r = {1'b1, sat24(b[`DATA_W-1] ? wb : -wb)};
        end else begin
          r = {1'b0, a};
        end
      end
      default: r = {1'b0, a};
    endcase
    return r;
  endfunction

  wire logic [`DATA_W:0] alu_out = alu_calc(i_ctl_word.alu_op, rounded, opnd_b);
  wire logic signed [`DATA_W-1:0] alu_res = alu_out[`DATA_W-1:0];
  wire filter_accelerator_pkg::shift_type shift =
    filter_accelerator_pkg::shift_type'(i_ctl_word.shift);
  // Left shift saturates; right shifts are arithmetic and simply drop bits.
  wire logic shl_ovf = alu_res[`DATA_W-1] != alu_res[`DATA_W-2];
  wire logic [`DATA_W-1:0] shl_res = shl_ovf ? (alu_res[`DATA_W-1] ? `NEG_MAX : `POS_MAX) :
    {alu_res[`DATA_W-2:0], 1'b0};
  wire logic [`DATA_W-1:0] shifted =
    (shift == filter_accelerator_pkg::SH_LEFT1) ? shl_res :
    (shift == filter_accelerator_pkg::SH_RIGHT1) ? `DATA_W'(alu_res >>> 1) :
    (shift == filter_accelerator_pkg::SH_RIGHT2) ? `DATA_W'(alu_res >>> 2) :
    alu_res;

  // Every field of the control word acts in the same cycle it is taken.
  wire logic to_hold = taken && !i_ctl_word.dest_out;
  wire logic to_out = taken && i_ctl_word.dest_out;

  // Stalling on a full buffer costs throughput but never loses a result.
  assign o_ctl_ready = buf_in_ready;
  assign o_alu_flag = alu_flag_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_smp_wr.we) smp_ram_ff[i_smp_wr.addr] <= i_smp_wr.data;
    if (i_coef_wr.we) coef_ram_ff[i_coef_wr.addr] <= i_coef_wr.data;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_ff <= `ACC_RST;
      hold_a_ff <= `HOLD_RST;
      hold_b_ff <= `HOLD_RST;
      alu_flag_ff <= 1'b0;
    end else begin
      if (taken) acc_ff <= nxt_acc;
      if (taken) alu_flag_ff <= alu_out[`DATA_W];
      if (to_hold) hold_a_ff <= shifted;
      if (to_hold) hold_b_ff <= hold_a_ff;
    end
  end

  result_buffer #(
    .WIDTH(`DATA_W),
    .DEPTH(`BUF_DEPTH)
  ) u_result_buffer (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_in_valid(to_out),
    .i_in_data(shifted),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_res_valid),
    .o_out_data(o_res_data),
    .i_out_ready(i_res_ready)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  mac_accumulate_a: assert property (
    taken && mac_op == filter_accelerator_pkg::MAC_ACC |=>
      acc_ff == $past(acc_ff) + $past(product))
    else $error("Accumulator did not add the product.");
  mac_load_a: assert property (
    taken && mac_op == filter_accelerator_pkg::MAC_LOAD |=> acc_ff == $past(product))
    else $error("Accumulator did not load the product.");
  tap_to_hold_a: assert property (
    to_hold && i_ctl_word.alu_op == 4'h0 && !i_ctl_word.round && i_ctl_word.shift == 2'h0
      |=> hold_a_ff == $past(acc_ff[`TAP_HI:`TAP_LO]))
    else $error("Holding register missed the accumulator tap.");
  fraction_point_a: assert property (
    taken && mac_op == filter_accelerator_pkg::MAC_LOAD && smp_rd == `HALF && coef_rd == `HALF
      |=> mac_tap == `QUARTER)
    else $error("Half times half did not give a quarter.");
  abs_positive_a: assert property (
    to_hold && i_ctl_word.alu_op == 4'h5 && i_ctl_word.shift == 2'h0 |=> !hold_a_ff[`DATA_W-1])
    else $error("Absolute value came out negative.");
  hold_chain_a: assert property (
    to_hold |=> hold_b_ff == $past(hold_a_ff) ##1 (!$past(to_hold) || hold_b_ff == $past(hold_a_ff)))
    else $error("Second holding register did not follow the first.");
  sample_store_a: assert property (
    i_smp_wr.we |=> smp_ram_ff[$past(i_smp_wr.addr)] == $past(i_smp_wr.data))
    else $error("Sample RAM did not store the write.");
  stall_freeze_a: assert property (
    !o_ctl_ready |=> $stable(acc_ff) && $stable(hold_a_ff))
    else $error("Datapath moved while stalled.");
  reset_clear_a: assert property (disable iff (1'b0)
    $rose(i_resetn) |-> acc_ff == `ACC_RST && hold_a_ff == `HOLD_RST && hold_b_ff == `HOLD_RST)
    else $error("Reset left datapath state behind.");

  tap_stream_c: cover property ((taken && mac_op == filter_accelerator_pkg::MAC_ACC) [*4]);
  result_out_c: cover property (to_out ##1 o_res_valid && i_res_ready);
  bank_top_c: cover property (taken && bank_sel == 2'h3);
  stall_c: cover property (i_ctl_valid && !o_ctl_ready);
endmodule
`default_nettype wire

// [dv/result_sink.sv]
// Model of the bus side that takes results away, able to stall on command.
`timescale 1ns/10ps
`default_nettype none
module result_sink (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_stall,
  input wire logic i_res_valid,
  input wire logic [23:0] i_res_data,
  output logic o_res_ready
);
  logic [23:0] got_q[$];
  // A stalled consumer refuses every word, so the block must hold its results.
  assign o_res_ready = !i_stall;
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      got_q.delete();
    end else if (i_res_valid && o_res_ready) begin
      got_q.push_back(i_res_data);
    end
  end
endmodule
`default_nettype wire

// [dv/test_fixed_point_filter_accelerator.sv]
// Testbench of the filter accelerator with a stalling result consumer.
`timescale 1ns/10ps
`default_nettype none
`include "filter_accelerator_regs.svh"
module test_fixed_point_filter_accelerator;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ctl_valid = 1'b0;
  filter_accelerator_pkg::ctl_word_type i_ctl_word = '0;
  filter_accelerator_pkg::ram_wr_type i_smp_wr = '0;
  filter_accelerator_pkg::ram_wr_type i_coef_wr = '0;
  logic stall = 1'b0;
  logic o_ctl_ready, o_res_valid, o_alu_flag, res_ready;
  logic [23:0] o_res_data;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  filter_accelerator DUT (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ctl_valid(i_ctl_valid),
    .i_ctl_word(i_ctl_word), .o_ctl_ready(o_ctl_ready), .i_smp_wr(i_smp_wr),
    .i_coef_wr(i_coef_wr), .o_res_valid(o_res_valid), .o_res_data(o_res_data),
    .i_res_ready(res_ready), .o_alu_flag(o_alu_flag));
  result_sink sink (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_stall(stall),
    .i_res_valid(o_res_valid), .i_res_data(o_res_data), .o_res_ready(res_ready));
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // The ceiling leaves ample margin over the fewer than a hundred cycles the tests need.
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic filter_accelerator_pkg::ctl_word_type mk(input logic [1:0] m,
      input logic [3:0] a, input logic [5:0] ad, input logic [1:0] b, input logic d,
      input logic r);
    return {m, a, ad, b, 2'h0, d, r};
  endfunction
  task automatic send(input filter_accelerator_pkg::ctl_word_type w);
    logic ok;
    ok = 1'b0;
    i_ctl_valid = 1'b1;
    i_ctl_word = w;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge i_sys_clk) ok = o_ctl_ready;
      @(posedge i_sys_clk);
      #1;
    end
    check("word taken", {23'h0, ok}, 24'h000001);
  endtask
  task automatic idle();
    i_ctl_valid = 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask
  // Back-to-back writes keep the strobe up; only the last one drops it.
  task automatic wr(input logic [5:0] ad, input logic [23:0] s, input logic [23:0] c,
      input logic last);
    i_smp_wr = {1'b1, ad, s};
    i_coef_wr = {1'b1, ad, c};
    @(posedge i_sys_clk);
    #1;
    if (last) begin
      i_smp_wr.we = 1'b0;
      i_coef_wr.we = 1'b0;
    end
  endtask
  task automatic pop(input logic [23:0] exp, input logic chk);
    for (int n = 0; n < 50 && sink.got_q.size() == 0; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (sink.got_q.size() == 0) check("result count", 24'h0, 24'h1);
    else if (chk) check("result", sink.got_q.pop_front(), exp);
    else void'(sink.got_q.pop_front());
  endtask
  task automatic t_reset();
    check("ready", {23'h0, o_ctl_ready}, 24'h000001);
    check("valid", {23'h0, o_res_valid}, 24'h000000);
    check("flag", {23'h0, o_alu_flag}, 24'h000000);
    send(mk(2'h0, 4'h1, 6'h00, 2'h0, 1'b1, 1'b0));
    idle();
    pop(24'h000000, 1'b1);
  endtask
  task automatic t_mac();
    wr(6'h03, 24'h400000, 24'h400000, 1'b0);
    wr(6'h04, 24'hC00000, 24'h400000, 1'b0);
    wr(6'h05, 24'h000001, 24'h400000, 1'b1);
    send(mk(2'h2, 4'h0, 6'h03, 2'h3, 1'b0, 1'b0));
    send(mk(2'h1, 4'h0, 6'h03, 2'h3, 1'b1, 1'b0));
    send(mk(2'h0, 4'h0, 6'h03, 2'h3, 1'b1, 1'b0));
    send(mk(2'h2, 4'h0, 6'h05, 2'h3, 1'b0, 1'b0));
    send(mk(2'h0, 4'h0, 6'h05, 2'h3, 1'b1, 1'b0));
    send(mk(2'h0, 4'h0, 6'h05, 2'h3, 1'b1, 1'b1));
    idle();
    pop(24'h200000, 1'b1);
    pop(24'h400000, 1'b1);
    pop(24'h000000, 1'b1);
    pop(24'h000001, 1'b1);
  endtask
  // Operand a is -0.25; b is the sample -0.5, hold_a 0, hold_b 0.5 or zero per op.
  task automatic t_alu();
    logic [23:0] ed[9] = '{24'hE00000, 24'hA00000, 24'h200000, 24'h000001, 24'h000001,
      24'h200000, 24'h000000, 24'h000000, 24'hE00000};
    logic [1:0] bs[9] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h0, 2'h3, 2'h1, 2'h3, 2'h3};
    logic [8:0] ef = 9'h0D8;
    send(mk(2'h2, 4'h0, 6'h04, 2'h3, 1'b0, 1'b0));
    for (int k = 0; k < 9; k++) begin
      send(mk(2'h0, 4'(k), 6'h04, bs[k], 1'b1, 1'b0));
      check("alu flag", {23'h0, o_alu_flag}, {23'h0, ef[k]});
    end
    idle();
    for (int k = 0; k < 9; k++) pop(ed[k], 1'b1);
  endtask
  // Left, right and double right shifts on the -0.25 tap, a saturating left shift, then an absolute value parked in hold_a.
  task automatic t_shift();
    filter_accelerator_pkg::ctl_word_type w;
    logic [23:0] ed[4] = '{24'hC00000, 24'hF00000, 24'hF80000, 24'h800000};
    for (int k = 0; k < 4; k++) begin
      w = mk(2'h0, (k == 3) ? 4'h2 : 4'h0, 6'h04, (k == 3) ? 2'h1 : 2'h3, 1'b1, 1'b0);
      w.shift = (k == 3) ? 2'h1 : 2'(k + 1);
      send(w);
    end
    send(mk(2'h0, 4'h5, 6'h04, 2'h3, 1'b0, 1'b0));
    send(mk(2'h0, 4'h1, 6'h04, 2'h0, 1'b1, 1'b0));
    idle();
    for (int k = 0; k < 4; k++) pop(ed[k], 1'b1);
    pop(24'h000000, 1'b1);
  endtask
  task automatic t_stall();
    stall = 1'b1;
    send(mk(2'h3, 4'h0, 6'h03, 2'h3, 1'b0, 1'b0));
    send(mk(2'h2, 4'h0, 6'h03, 2'h3, 1'b1, 1'b0));
    send(mk(2'h1, 4'h0, 6'h03, 2'h3, 1'b1, 1'b0));
    i_ctl_word = mk(2'h0, 4'h0, 6'h03, 2'h3, 1'b1, 1'b0);
    @(negedge i_sys_clk);
    check("ready full", {23'h0, o_ctl_ready}, 24'h000000);
    check("held valid", {23'h0, o_res_valid}, 24'h000001);
    check("held data", o_res_data, 24'h000000);
    @(posedge i_sys_clk);
    #1;
    stall = 1'b0;
    send(mk(2'h0, 4'h0, 6'h03, 2'h3, 1'b1, 1'b0));
    idle();
    pop(24'h000000, 1'b1);
    pop(24'h200000, 1'b1);
    pop(24'h400000, 1'b1);
  endtask
  // A reset in mid-run must wipe a non-zero accumulator, both holds and the flag.
  task automatic t_rereset();
    send(mk(2'h0, 4'h4, 6'h03, 2'h3, 1'b1, 1'b0));
    check("flag before reset", {23'h0, o_alu_flag}, 24'h000001);
    idle();
    pop(24'h000001, 1'b1);
    i_resetn = 1'b0;
    @(posedge i_sys_clk);
    #1;
    check("ready in reset", {23'h0, o_ctl_ready}, 24'h000001);
    check("valid in reset", {23'h0, o_res_valid}, 24'h000000);
    check("flag in reset", {23'h0, o_alu_flag}, 24'h000000);
    i_resetn = 1'b1;
    send(mk(2'h0, 4'h1, 6'h03, 2'h0, 1'b1, 1'b0));
    send(mk(2'h0, 4'h1, 6'h03, 2'h1, 1'b1, 1'b0));
    idle();
    pop(24'h000000, 1'b1);
    pop(24'h000000, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_resetn = 1'b1;
    t_reset();
    t_mac();
    t_alu();
    t_shift();
    t_stall();
    t_rereset();
    report_and_stop();
  end
endmodule
`default_nettype wire
